// ===== logic/ext_decode_pkg.sv
// constants, types and state codes for the extended instruction decoder
package ext_decode_pkg;
  localparam int PTR_W = 12;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int NUM_PTR = 3;
  localparam logic [7:0] OPC_PTR_ADD = 8'hE8;
  localparam logic [7:0] OPC_PTR_SUB = 8'hE9;
  localparam logic [7:0] OPC_PUSH = 8'hEA;
  localparam logic [7:0] OPC_MOVE = 8'hEB;
  localparam logic [15:0] OPC_CALL_WORK = 16'h0014;
  localparam logic [3:0] OPC_SECOND = 4'hF;
  localparam logic [1:0] SEL_PTR2 = 2'h3;
  localparam logic [PTR_W-1:0] PTR_RST = 12'h000;
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam int MOVE_MODE_BIT = 7;
  localparam int ACCESS_BIT = 8;

  typedef enum logic [2:0] {ST_IDLE, ST_RET, ST_CALL, ST_MV_RD, ST_MV_CAP, ST_MV_W2} dec_state_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [PTR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic call;
    logic ret;
    logic [DATA_W-1:0] target;
  } flow_type;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] word;
    logic idx_en;
    logic [PTR_W-1:0] idx_addr;
  } std_op_type;
endpackage : ext_decode_pkg

// ===== logic/extended_instruction_decoder.sv
// decode and execution of the extended instruction set
`timescale 1ns/10ps
module extended_instruction_decoder
  import ext_decode_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // configuration
  input wire logic extension_config_bit_in,
  // instruction fetch
  input wire logic instr_valid_in,
  input wire logic [WORD_W-1:0] instr_word_in,
  output logic instr_ready_out,
  // core datapath
  input wire logic [DATA_W-1:0] working_register_in,
  input wire logic [DATA_W-1:0] mem_rdata_in,
  output mem_req_type mem_req_out,
  output flow_type flow_out,
  output std_op_type std_op_out,
  output logic ext_done_out,
  output logic [PTR_W-1:0] ptr0_out,
  output logic [PTR_W-1:0] ptr1_out,
  output logic [PTR_W-1:0] pointer_two_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [PTR_W-1:0] add_off(input logic [PTR_W-1:0] base, input logic [DATA_W-1:0] off);
    add_off = base + {4'h0, off};
  endfunction : add_off

  function automatic logic is_file_op(input logic [WORD_W-1:0] w);
    is_file_op = ((w[15:12] >= 4'h1) && (w[15:12] <= 4'hB)) || ((w[15:12] == 4'h0) && (w[11:10] != 2'h0));
  endfunction : is_file_op

  function automatic logic [PTR_W-1:0] sub_off(input logic [PTR_W-1:0] base, input logic [DATA_W-1:0] off);
    sub_off = base - {4'h0, off};
  endfunction : sub_off

  function automatic logic [1:0] ptr_index(input logic [1:0] sel);
    ptr_index = (sel == SEL_PTR2) ? 2'h2 : sel;
  endfunction : ptr_index

  ////////////////////////////////////////////////////////////////////////////
  // state
  dec_state_type state_ff;
  dec_state_type nxt_state;
  logic ext_en_ff;
  logic [NUM_PTR-1:0][PTR_W-1:0] ptr_ff;
  logic [NUM_PTR-1:0][PTR_W-1:0] nxt_ptr;
  logic [DATA_W-1:0] mv_data_ff;
  logic [DATA_W-1:0] nxt_mv_data;
  logic mv_idx_ff;
  logic nxt_mv_idx;
  mem_req_type mem_ff;
  mem_req_type nxt_mem;
  flow_type flow_ff;
  flow_type nxt_flow;
  std_op_type std_ff;
  std_op_type nxt_std;
  logic done_ff;
  logic nxt_done;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic accept = instr_valid_in && instr_ready_out;
  wire logic [7:0] opc_hi = instr_word_in[15:8];
  wire logic [1:0] ptr_sel = instr_word_in[7:6];
  wire logic [DATA_W-1:0] lit6 = {2'h0, instr_word_in[5:0]};
  wire logic [DATA_W-1:0] lit8 = instr_word_in[7:0];
  wire logic [DATA_W-1:0] off7 = {1'b0, instr_word_in[6:0]};
  wire logic dec_add = ext_en_ff && (opc_hi == OPC_PTR_ADD);
  wire logic dec_sub = ext_en_ff && (opc_hi == OPC_PTR_SUB);
  wire logic dec_push = ext_en_ff && (opc_hi == OPC_PUSH);
  wire logic dec_move = ext_en_ff && (opc_hi == OPC_MOVE);
  wire logic dec_call_work = ext_en_ff && (instr_word_in == OPC_CALL_WORK);
  wire logic is_second = instr_word_in[15:12] == OPC_SECOND;
  wire logic idx_hit = ext_en_ff && is_file_op(instr_word_in) && !instr_word_in[ACCESS_BIT]
    && (lit8 <= IDX_LIMIT);
  wire logic [PTR_W-1:0] idx_addr = add_off(ptr_ff[2], lit8);
  wire logic ret_form = ptr_sel == SEL_PTR2;
  wire logic [1:0] ptr_idx = ptr_index(ptr_sel);
  wire logic [PTR_W-1:0] sel_ptr = ptr_ff[ptr_idx];
  wire logic [PTR_W-1:0] sel_sum = add_off(sel_ptr, lit6);
  wire logic [PTR_W-1:0] sel_dif = sub_off(sel_ptr, lit6);
  wire logic [PTR_W-1:0] mv_src = add_off(ptr_ff[2], off7);
  wire logic [PTR_W-1:0] mv_dst_idx = add_off(ptr_ff[2], off7);
  wire logic [PTR_W-1:0] mv_dst_abs = instr_word_in[PTR_W-1:0];

  assign instr_ready_out = (state_ff == ST_IDLE) || (state_ff == ST_MV_W2);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_ptr = ptr_ff;
    nxt_mv_data = mv_data_ff;
    nxt_mv_idx = mv_idx_ff;
    nxt_mem = '0;
    nxt_flow = '0;
    nxt_std = '0;
    nxt_done = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (accept)
        begin
          if (dec_add)
          begin
            nxt_ptr[ptr_idx] = sel_sum;
            nxt_done = !ret_form;
            if (ret_form)
            begin
              nxt_state = ST_RET;
            end
          end
          else if (dec_sub)
          begin
            nxt_ptr[ptr_idx] = sel_dif;
            nxt_done = !ret_form;
            if (ret_form)
            begin
              nxt_state = ST_RET;
            end
          end
          else if (dec_push)
          begin
            nxt_mem.wr = 1'b1;
            nxt_mem.addr = ptr_ff[2];
            nxt_mem.wdata = lit8;
            nxt_ptr[2] = sub_off(ptr_ff[2], 8'h01);
            nxt_done = 1'b1;
          end
          else if (dec_call_work)
          begin
            nxt_flow.call = 1'b1;
            nxt_flow.target = working_register_in;
            nxt_state = ST_CALL;
          end
          else if (dec_move)
          begin
            nxt_mem.rd = 1'b1;
            nxt_mem.addr = mv_src;
            nxt_mv_idx = instr_word_in[MOVE_MODE_BIT];
            nxt_state = ST_MV_RD;
          end
          else
          begin
            nxt_std.valid = 1'b1;
            nxt_std.word = instr_word_in;
            nxt_std.idx_en = idx_hit;
            nxt_std.idx_addr = idx_hit ? idx_addr : PTR_RST;
          end
        end
      end
      ST_RET:
      begin
        nxt_flow.ret = 1'b1;
        nxt_done = 1'b1;
        nxt_state = ST_IDLE;
      end
      ST_CALL:
      begin
        nxt_done = 1'b1;
        nxt_state = ST_IDLE;
      end
      ST_MV_RD:
      begin
        nxt_state = ST_MV_CAP;
      end
      ST_MV_CAP:
      begin
        nxt_mv_data = mem_rdata_in;
        nxt_state = ST_MV_W2;
      end
      ST_MV_W2:
      begin
        if (accept)
        begin
          nxt_state = ST_IDLE;
          nxt_done = 1'b1;
          if (is_second)
          begin
            nxt_mem.wr = 1'b1;
            nxt_mem.addr = mv_idx_ff ? mv_dst_idx : mv_dst_abs;
            nxt_mem.wdata = mv_data_ff;
          end
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      ext_en_ff <= extension_config_bit_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      state_ff <= ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      ptr_ff <= {NUM_PTR{PTR_RST}};
    end
    else
    begin
      ptr_ff <= nxt_ptr;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      mv_data_ff <= '0;
    end
    else
    begin
      mv_data_ff <= nxt_mv_data;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      mv_idx_ff <= 1'b0;
    end
    else
    begin
      mv_idx_ff <= nxt_mv_idx;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      mem_ff <= '0;
    end
    else
    begin
      mem_ff <= nxt_mem;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      flow_ff <= '0;
    end
    else
    begin
      flow_ff <= nxt_flow;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      std_ff <= '0;
    end
    else
    begin
      std_ff <= nxt_std;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= nxt_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign mem_req_out = mem_ff;
  assign flow_out = flow_ff;
  assign std_op_out = std_ff;
  assign ext_done_out = done_ff;
  assign ptr0_out = ptr_ff[0];
  assign ptr1_out = ptr_ff[1];
  assign pointer_two_out = ptr_ff[2];

endmodule : extended_instruction_decoder

// ===== verif/ext_dec_monitor.sv
// assertions on the extended decoder ports
`timescale 1ns/10ps
module ext_dec_monitor
  import ext_decode_pkg::*;
(
  // clock, reset, configuration
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic extension_config_bit_in,
  // fetch and core side
  input wire logic instr_valid_in,
  input wire logic [WORD_W-1:0] instr_word_in,
  input wire logic instr_ready_out,
  input wire logic [DATA_W-1:0] working_register_in,
  input wire mem_req_type mem_req_out,
  input wire flow_type flow_out,
  input wire std_op_type std_op_out,
  input wire logic ext_done_out,
  input wire logic [PTR_W-1:0] ptr0_out,
  input wire logic [PTR_W-1:0] pointer_two_out
);
  logic ext_ff;
  wire [15:0] w = instr_word_in;
  wire te = instr_valid_in && instr_ready_out && ext_ff;
  wire [11:0] p2 = pointer_two_out;
  always_ff @(posedge clk_sys_in)
    if (srst_in) ext_ff <= extension_config_bit_in;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  a_ext_off: assert property (instr_valid_in && instr_ready_out && !ext_ff |=> std_op_out.valid
    && std_op_out.word == $past(w) && !ext_done_out) else $error("word not passed through");
  a_ptr_add: assert property (te && w[15:6] == {OPC_PTR_ADD, 2'h0} |=>
    ptr0_out == $past(ptr0_out) + 12'($past(w[5:0])) && ext_done_out) else $error("pointer add wrong");
  a_add_ret: assert property (te && w[15:6] == {OPC_PTR_ADD, SEL_PTR2} |=> p2 == $past(p2) +
    12'($past(w[5:0])) && !instr_ready_out && !flow_out.ret ##1 flow_out.ret) else $error("add return wrong");
  a_sub_ret: assert property (te && w[15:6] == {OPC_PTR_SUB, SEL_PTR2} |=> p2 == $past(p2) -
    12'($past(w[5:0])) && !flow_out.ret ##1 flow_out.ret && ext_done_out) else $error("sub return wrong");
  a_call_work: assert property (te && w == OPC_CALL_WORK |=> flow_out.call &&
    flow_out.target == $past(working_register_in) ##1 ext_done_out) else $error("call wrong");
  a_push_lit: assert property (te && w[15:8] == OPC_PUSH |=> mem_req_out.wr && mem_req_out.wdata == $past(w[7:0])
    && mem_req_out.addr == $past(p2) && p2 == $past(p2) - 12'h001) else $error("push wrong");
  a_move_src: assert property (te && w[15:8] == OPC_MOVE |=> mem_req_out.rd && mem_req_out.addr == $past(p2) +
    12'($past(w[6:0])) && !instr_ready_out ##1 !instr_ready_out ##1 instr_ready_out) else $error("move read wrong");
  a_no_flags: assert property (te && (w[15:10] == 6'h3A || w == OPC_CALL_WORK) |=>
    !std_op_out.valid) else $error("extended op leaked to core");
  a_idx_addr: assert property (te && w[15:12] == 4'h6 && !w[8] && w[7:0] <= IDX_LIMIT |=>
    std_op_out.idx_en && std_op_out.idx_addr == $past(p2) + 12'($past(w[7:0]))) else $error("indexed address wrong");
  c_move: cover property (te && w[15:8] == OPC_MOVE);
  c_ret: cover property (flow_out.ret);
  c_call: cover property (flow_out.call);
endmodule : ext_dec_monitor
bind extended_instruction_decoder ext_dec_monitor mon (.*);

// ===== verif/data_mem_model.sv
// data memory model answering decoder reads
`timescale 1ns/10ps
module data_mem_model
  import ext_decode_pkg::*;
(
  // clock and request
  input wire logic clk_sys_in,
  input wire mem_req_type mem_req_in,
  // read data
  output logic [DATA_W-1:0] rdata_out
);
  initial rdata_out = 8'h00;
  // data only held the cycle after a read, scrambled otherwise
  always @(posedge clk_sys_in)
    rdata_out <= mem_req_in.rd ? mem_req_in.addr[7:0] ^ 8'hA5 : ~rdata_out;
endmodule : data_mem_model

// ===== verif/tb.sv
// self-checking bench for the extended decoder
`timescale 1ns/10ps
module tb;
  import ext_decode_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic cfg = 1'b0;
  logic v = 1'b0;
  logic [WORD_W-1:0] w = WORD_RST;
  logic [DATA_W-1:0] work_reg = 8'h00;
  logic [DATA_W-1:0] rd;
  logic rdy, done;
  mem_req_type mq;
  flow_type fl;
  std_op_type so;
  logic [PTR_W-1:0] p0, p1, p2;
  logic [PTR_W-1:0] ep [3];
  mem_req_type wq [$];
  std_op_type sq [$];
  flow_type fq [$];
  logic [WORD_W-1:0] dis [4] = '{16'hE855, 16'h0014, 16'hEA12, 16'hEB81};
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_done = 0;
  int j;
  logic [7:0] k;
  logic [6:0] z;
  always #25 clk_sys_in = ~clk_sys_in;
  extended_instruction_decoder uut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .extension_config_bit_in(cfg),
    .instr_valid_in(v), .instr_word_in(w), .instr_ready_out(rdy), .working_register_in(work_reg),
    .mem_rdata_in(rd), .mem_req_out(mq), .flow_out(fl), .std_op_out(so), .ext_done_out(done),
    .ptr0_out(p0), .ptr1_out(p1), .pointer_two_out(p2));
  data_mem_model mem (.clk_sys_in(clk_sys_in), .mem_req_in(mq), .rdata_out(rd));
  task automatic chk(input logic [29:0] seen, input logic [29:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic issue(input logic [15:0] x);
    v <= 1'b1;
    w <= x;
    do @(posedge clk_sys_in); while (rdy !== 1'b1);
  endtask : issue
  task automatic rst(input logic c);
    v <= 1'b0;
    cfg <= c;
    srst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    ep = '{12'h000, 12'h000, 12'h000};
  endtask : rst
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // scoreboard on registered outputs
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (mq.wr === 1'b1) chk(30'(mq), 30'(wq.pop_front()));
    if (so.valid === 1'b1) chk(30'(so), 30'(sq.pop_front()));
    if (fl.call === 1'b1 || fl.ret === 1'b1) chk(30'(fl), 30'(fq.pop_front()));
    if (done === 1'b1) n_done++;
    if (cyc == 3000)
    begin
      n_fail++;
      test_done();
    end
  end
  initial
  begin
    void'($urandom(32'h3a57b572));
    rst(1'b0);
    foreach (dis[i])
    begin
      sq.push_back(std_op_type'({1'b1, dis[i], 13'h0000}));
      issue(dis[i]);
    end
    rst(1'b1);
    for (int i = 0; i < 8; i++)
    begin
      k = 8'($urandom);
      j = (i[2:1] == 2'h3) ? 2 : int'(i[2:1]);
      ep[j] = i[0] ? ep[j] - 12'(k[5:0]) : ep[j] + 12'(k[5:0]);
      if (i[2:1] == 2'h3) fq.push_back(flow_type'({2'h1, 8'h00}));
      issue({7'h74, i[0], i[2:1], k[5:0]});
    end
    sq.push_back(std_op_type'({1'b1, 16'h6A10, 1'b1, ep[2] + 12'h010}));
    issue(16'h6A10);
    repeat (3)
    begin
      k = 8'($urandom);
      wq.push_back(mem_req_type'({2'h1, ep[2], k}));
      ep[2] = ep[2] - 12'h001;
      issue({OPC_PUSH, k});
    end
    k = 8'($urandom);
    work_reg <= k;
    fq.push_back(flow_type'({2'h2, k}));
    issue(OPC_CALL_WORK);
    z = 7'($urandom);
    wq.push_back(mem_req_type'({2'h1, 12'h35C, 8'(ep[2] + 12'(z)) ^ 8'hA5}));
    issue({OPC_MOVE, 1'b0, z});
    issue({OPC_SECOND, 12'h35C});
    k = 8'($urandom);
    wq.push_back(mem_req_type'({2'h1, ep[2] + 12'(k[6:0]), 8'(ep[2] + 12'(z)) ^ 8'hA5}));
    issue({OPC_MOVE, 1'b1, z});
    issue({OPC_SECOND, 5'h00, k[6:0]});
    issue({OPC_MOVE, 1'b0, z});
    issue(16'h1234);
    v <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk(30'(p0), 30'(ep[0]));
    chk(30'(p1), 30'(ep[1]));
    chk(30'(p2), 30'(ep[2]));
    chk(30'(n_done), 30'h0000000F);
    chk(30'(wq.size() + sq.size() + fq.size()), 30'h00000000);
    test_done();
  end
endmodule : tb
